// [dv/pin_change_irq_flags_tb.sv]
/*
 * Self-checking bench for the pin-change and external interrupt flags.
 * Assumes the design package and a single 250 MHz clock domain; the
 * bench plays the register bus master, the pins and the core side.
 */
`default_nettype none
module pin_change_irq_flags_tb;
    import pin_change_irq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // signals
    logic aclk, aresetn;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [N_EXT-1:0] ext_irq_inputs;
    logic [N_PINS-1:0] pin_change_inputs;
    logic sleep_active, vector_taken, vector_request, irq;
    logic [3:0] vector_number;
    int err_count = 0;
    int comparisons = 0;
    logic [1:0] resp;
    logic [31:0] data;

    pin_change_irq_flags u_pin_change_irq_flags (.*);

    // ==========================================================
    // clock, 4 ns period
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // ==========================================================
    // bus master: each channel held until its own handshake
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        int n;
        n = 0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, val};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 200);
        resp = s_axi_bresp;
        if (n >= 200) err_count++;
    endtask

    task automatic rd(input logic [7:0] idx);
        int n;
        n = 0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 200);
        data = s_axi_rdata;
        resp = s_axi_rresp;
        if (n >= 200) err_count++;
    endtask

    // read a register and compare with the full 32-bit word
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        rd(idx);
        chk($sformatf("reg %0h", idx), data, {24'h000000, exp});
    endtask

    // one-cycle acknowledge from the core
    task automatic take();
        vector_taken <= 1'b1;
        @(posedge aclk);
        vector_taken <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    // ==========================================================
    // watchdog at 50000 cycles: the whole run needs well under that
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end

    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] regs [6];
        regs = '{IDX_PC_FLAGS, IDX_PC_GROUP_ENABLE, IDX_PC_MASK0,
                 IDX_PC_MASK1, IDX_PC_MASK2, IDX_PC_MASK3};
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid} = '0;
        // answers always accepted, so back-to-back calls never re-raise
        s_axi_bready = 1'b1;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
        s_axi_wstrb = 4'hF;
        ext_irq_inputs = '0;
        pin_change_inputs = '0;
        sleep_active = 1'b0;
        vector_taken = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // reset values, then mask read/write and reserved bits
        foreach (regs[i]) rdc(regs[i], 8'h00);
        for (int i = 2; i < 6; i++) begin
            wr(regs[i], 8'hA5);
            rdc(regs[i], 8'hA5);
            wr(regs[i], 8'h00);
        end
        wr(IDX_PC_GROUP_ENABLE, 8'hFF);
        rdc(IDX_PC_GROUP_ENABLE, 8'h0F);
        wr(8'h00, 8'h01);
        chk("write resp", 32'(resp), 32'(RESP_SLVERR));
        rd(8'h00);
        chk("read resp", 32'(resp), 32'(RESP_SLVERR));
        wr(IDX_STATUS, 8'h80);
        // one mask bit per group; an unmasked-out pin must stay silent
        for (int g = 0; g < 4; g++) begin
            wr(regs[g + 2], 8'(1 << g));
            pin_change_inputs[8 * g + ((g + 1) % 8)] <= 1'b1;
            repeat (3) @(posedge aclk);
            rdc(IDX_PC_FLAGS, 8'h00);
            pin_change_inputs[8 * g + g] <= 1'b1;
            repeat (3) @(posedge aclk);
            chk("vec req", 32'(vector_request), 32'h1);
            chk("vec num", 32'(vector_number),
                32'(VEC_GRP_BASE + 4'(g)));
            rdc(IDX_PC_FLAGS, 8'(1 << g));
            take();
            rdc(IDX_PC_FLAGS, 8'h00);
        end
        // irq status, mask and clear
        rdc(IDX_IRQ_STATUS, 8'h78);
        chk("irq masked", 32'(irq), 32'h0);
        wr(IDX_IRQ_MASK, 8'h08);
        // irq is registered one cycle behind the mask
        @(posedge aclk);
        chk("irq on", 32'(irq), 32'h1);
        wr(IDX_IRQ_STATUS, 8'h08);
        @(posedge aclk);
        chk("irq off", 32'(irq), 32'h0);
        wr(IDX_IRQ_STATUS, 8'h7F);
        // disabled group ignores its pins
        wr(IDX_PC_GROUP_ENABLE, 8'h00);
        pin_change_inputs[0] <= 1'b0;
        repeat (3) @(posedge aclk);
        rdc(IDX_PC_FLAGS, 8'h00);
        // sense codes: ext0 rise, ext1 fall, ext2 any
        wr(IDX_SENSE_CONTROL, 8'h1B);
        wr(IDX_EXT_FLAGS, 8'h07);
        ext_irq_inputs <= 3'b111;
        repeat (3) @(posedge aclk);
        rdc(IDX_EXT_FLAGS, 8'h05);
        wr(IDX_EXT_FLAGS, 8'h05);
        rdc(IDX_EXT_FLAGS, 8'h00);
        ext_irq_inputs <= 3'b000;
        repeat (3) @(posedge aclk);
        rdc(IDX_EXT_FLAGS, 8'h06);
        wr(IDX_SENSE_CONTROL, 8'h00);
        rdc(IDX_EXT_FLAGS, 8'h00);
        // sleep clamp on a disabled, high pin makes a change
        wr(IDX_SENSE_CONTROL, 8'h01);
        ext_irq_inputs <= 3'b001;
        repeat (3) @(posedge aclk);
        wr(IDX_EXT_FLAGS, 8'h07);
        rdc(IDX_EXT_FLAGS, 8'h00);
        sleep_active <= 1'b1;
        repeat (3) @(posedge aclk);
        rdc(IDX_EXT_FLAGS, 8'h01);
        sleep_active <= 1'b0;
        wr(IDX_EXT_ENABLE, 8'h01);
        repeat (4) @(posedge aclk);
        chk("ext req", 32'(vector_request), 32'h1);
        chk("ext num", 32'(vector_number), 32'(VEC_EXT_BASE));
        rdc(IDX_VECTOR, 8'h11);
        take();
        rdc(IDX_EXT_FLAGS, 8'h00);
        chk("ext idle", 32'(vector_request), 32'h0);
        // ext1 sits low in level mode: a request with no flag behind it
        wr(IDX_EXT_ENABLE, 8'h02);
        repeat (4) @(posedge aclk);
        chk("lvl req", 32'(vector_request), 32'h1);
        chk("lvl num", 32'(vector_number),
            32'(VEC_EXT_BASE + 4'h1));
        rdc(IDX_EXT_FLAGS, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire

// [verilog/pin_change_irq_flags.sv]
/*
 * Interrupt flags, enables and vectoring for three external inputs and
 * four pin-change groups of eight inputs, with an AXI4-Lite slave.
 * Assumes pins already synchronous to aclk and a core that acknowledges
 * the presented vector with a one-cycle vector_taken pulse.
 */
// Added by the designer: register access over AXI4-Lite.
// Functional notes
// - edge or change sets external flag
// - enabled flag vectors; taking vector clears it
// - writing one clears a flag
// - low-level sense holds flag cleared
// - sleep clamps disabled external inputs low
// - group enable gates its eight inputs
// - any unmasked change raises group request
// - each group has own vector
// - group change sets group flag
// - enabled group flag vectors; service clears it
// - mask bit enables detection per input
// - mask register n maps to inputs 8n+7..8n
// - sense codes low, any, falling, rising
// - enable plus global enables external interrupt
`default_nettype none
module pin_change_irq_flags
    import pin_change_irq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [N_EXT-1:0] ext_irq_inputs,
    input wire logic [N_PINS-1:0] pin_change_inputs,
    input wire logic sleep_active,
    input wire logic vector_taken,
    output logic vector_request,
    output logic [3:0] vector_number,
    output logic irq
);
    // ==========================================================
    // register state
    logic [N_EXT-1:0] ext_irq_flags_q;
    logic [N_EXT-1:0] ext_irq_enable_q;
    logic [2*N_EXT-1:0] sense_control_q;
    logic [N_GRP-1:0] pin_change_flags_q;
    logic [N_GRP-1:0] group_enable_q;
    logic [GRP_W-1:0] pin_change_mask_q [N_GRP];
    logic global_enable_q;
    logic [N_EV-1:0] irq_status_q;
    logic [N_EV-1:0] irq_mask_q;
    logic [N_EXT-1:0] ext_prev_q;
    logic [N_PINS-1:0] pc_prev_q;
    logic [N_EXT-1:0] ext_eff;
    logic [N_EXT-1:0] ext_event;
    logic [N_EXT-1:0] level_mode;
    logic [N_GRP-1:0] grp_event;
    logic [N_PINS-1:0] pin_changed;

    // ==========================================================
    // AXI4-Lite write channel: address and data latched in any order
    logic aw_held_q, w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic [7:0] wr_idx;
    logic wr_lane0;
    logic [7:0] wbyte;
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_idx = awaddr_q[ADDR_W-1:2];
    assign wr_lane0 = wstrb_q[0];
    assign wbyte = wdata_q[7:0];

    // address and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // each ready only while its own channel holds nothing and no response waits, so one write at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready)
                && !s_axi_bvalid;
            s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready)
                && !s_axi_bvalid;
        end
    end

    // decode of the write index, unmapped answers SLVERR
    logic wr_known;
    always_comb begin
        unique case (wr_idx)
            IDX_PC_FLAGS, IDX_EXT_FLAGS, IDX_EXT_ENABLE,
            IDX_PC_GROUP_ENABLE, IDX_SENSE_CONTROL, IDX_PC_MASK0,
            IDX_PC_MASK1, IDX_PC_MASK2, IDX_PC_MASK3, IDX_STATUS,
            IDX_VECTOR, IDX_IRQ_STATUS, IDX_IRQ_MASK: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // write strobes per register, byte lane 0 only
    logic wr_en;
    assign wr_en = wr_fire && wr_lane0;

    // ==========================================================
    // control registers written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_irq_enable_q <= REG_RESET[N_EXT-1:0];
            sense_control_q <= REG_RESET[2*N_EXT-1:0];
            group_enable_q <= REG_RESET[N_GRP-1:0];
            global_enable_q <= 1'b0;
            irq_mask_q <= REG_RESET[N_EV-1:0];
        end else if (wr_en) begin
            if (wr_idx == IDX_EXT_ENABLE)
                ext_irq_enable_q <= wbyte[N_EXT-1:0];
            if (wr_idx == IDX_SENSE_CONTROL)
                sense_control_q <= wbyte[2*N_EXT-1:0];
            // upper nibble dropped so reserved bits stay zero
            if (wr_idx == IDX_PC_GROUP_ENABLE)
                group_enable_q <= wbyte[N_GRP-1:0];
            if (wr_idx == IDX_STATUS)
                global_enable_q <= wbyte[GLOBAL_EN_BIT];
            if (wr_idx == IDX_IRQ_MASK)
                irq_mask_q <= wbyte[N_EV-1:0];
        end
    end

    // ==========================================================
    // per-group masks and change detection
    genvar g;
    generate
        for (g = 0; g < N_GRP; g++) begin : gen_grp
            always_ff @(posedge aclk) begin
                if (!aresetn)
                    pin_change_mask_q[g] <= REG_RESET;
                else if (wr_en && wr_idx == (g == 3 ? IDX_PC_MASK3 :
                        IDX_PC_MASK0 + 8'(g)))
                    pin_change_mask_q[g] <= wbyte;
            end
            // enabled pins only: mask bit and group enable
            assign grp_event[g] = group_enable_q[g] &&
                |(pin_changed[g*GRP_W +: GRP_W] &
                  pin_change_mask_q[g]);
        end
    endgenerate

    // both directions count; an xor against the last sample
    assign pin_changed = pin_change_inputs ^ pc_prev_q;

    // previous samples; reset value zero shows a high pin as changed for one cycle, while masks and enables are still zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_prev_q <= '0;
            ext_prev_q <= '0;
        end else begin
            pc_prev_q <= pin_change_inputs;
            ext_prev_q <= ext_eff;
        end
    end

    // ==========================================================
    // external inputs: sleep clamps the buffer of a disabled pin
    genvar e;
    generate
        for (e = 0; e < N_EXT; e++) begin : gen_ext
            logic [1:0] sc;
            assign sc = sense_control_q[2*e +: 2];
            // clamp low in sleep unless interrupt enabled
            assign ext_eff[e] = ext_irq_inputs[e] &&
                !(sleep_active && !ext_irq_enable_q[e]);
            assign level_mode[e] = (sc == SENSE_LOW);
            always_comb begin
                unique case (sense_type'(sc))
                    SENSE_LOW: ext_event[e] = 1'b0;
                    SENSE_ANY: ext_event[e] = ext_eff[e] ^ ext_prev_q[e];
                    SENSE_FALL: ext_event[e] = !ext_eff[e] && ext_prev_q[e];
                    SENSE_RISE: ext_event[e] = ext_eff[e] && !ext_prev_q[e];
                endcase
            end
        end
    endgenerate

    // ==========================================================
    // vector arbitration: external first, then groups, low number wins
    logic [N_EV-1:0] pending;
    logic [3:0] sel_vec;
    logic sel_any;
    logic [N_EXT-1:0] lvl_req;
    // low level requests while held low and enabled, never a flag
    assign lvl_req = level_mode & ~ext_irq_inputs & ext_irq_enable_q;
    assign pending = {pin_change_flags_q & group_enable_q,
        (ext_irq_flags_q | lvl_req) & ext_irq_enable_q};
    always_comb begin
        sel_vec = VEC_NONE;
        sel_any = 1'b0;
        for (int i = N_EV - 1; i >= 0; i--) begin
            if (pending[i]) begin
                sel_vec = VEC_EXT_BASE + 4'(i);
                sel_any = 1'b1;
            end
        end
    end

    // vector held stable until taken; global enable gates it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vector_request <= 1'b0;
            vector_number <= VEC_NONE;
        end else if (vector_taken) begin
            // drop for a cycle: pending still shows the flag being cleared
            vector_request <= 1'b0;
            vector_number <= VEC_NONE;
        end else if (!vector_request) begin
            vector_request <= sel_any && global_enable_q;
            vector_number <= (sel_any && global_enable_q) ? sel_vec
                : VEC_NONE;
        end
    end

    logic [N_EV-1:0] taken_clr;
    always_comb begin
        taken_clr = '0;
        if (vector_taken && vector_request)
            for (int i = 0; i < N_EV; i++)
                if (vector_number == VEC_EXT_BASE + 4'(i))
                    taken_clr[i] = 1'b1;
    end

    // ==========================================================
    // flags: set beats every clear in the same cycle
    logic [N_EXT-1:0] ext_w1c;
    logic [N_GRP-1:0] pc_w1c;
    assign ext_w1c = (wr_en && wr_idx == IDX_EXT_FLAGS) ?
        wbyte[N_EXT-1:0] : '0;
    assign pc_w1c = (wr_en && wr_idx == IDX_PC_FLAGS) ?
        wbyte[N_GRP-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_irq_flags_q <= '0;
        end else begin
            ext_irq_flags_q <= (ext_event | (ext_irq_flags_q & ~ext_w1c
                & ~taken_clr[N_EXT-1:0])) & ~level_mode;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_change_flags_q <= '0;
        end else begin
            pin_change_flags_q <= grp_event | (pin_change_flags_q & ~pc_w1c
                & ~taken_clr[N_EV-1:N_EXT]);
        end
    end

    // ==========================================================
    // summary interrupt: sticky events, masked, write one to clear
    logic [N_EV-1:0] irq_w1c;
    assign irq_w1c = (wr_en && wr_idx == IDX_IRQ_STATUS) ?
        wbyte[N_EV-1:0] : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_q <= '0;
            irq <= 1'b0;
        end else begin
            irq_status_q <= {grp_event, ext_event} | (irq_status_q & ~irq_w1c);
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

    // ==========================================================
    // read channel, answer one cycle after the address is taken
    logic [7:0] rbyte;
    logic rd_known;
    logic [7:0] rd_idx;
    assign rd_idx = s_axi_araddr[ADDR_W-1:2];
    always_comb begin
        rbyte = 8'h00;
        rd_known = 1'b1;
        unique case (rd_idx)
            IDX_PC_FLAGS: rbyte = {4'h0, pin_change_flags_q};
            IDX_EXT_FLAGS: rbyte = {5'h00, ext_irq_flags_q};
            IDX_EXT_ENABLE: rbyte = {5'h00, ext_irq_enable_q};
            IDX_PC_GROUP_ENABLE: rbyte = {4'h0, group_enable_q};
            IDX_SENSE_CONTROL: rbyte = {2'h0, sense_control_q};
            IDX_PC_MASK0: rbyte = pin_change_mask_q[0];
            IDX_PC_MASK1: rbyte = pin_change_mask_q[1];
            IDX_PC_MASK2: rbyte = pin_change_mask_q[2];
            IDX_PC_MASK3: rbyte = pin_change_mask_q[3];
            IDX_STATUS: rbyte = {global_enable_q, 7'h00};
            IDX_VECTOR: rbyte = {3'h0, vector_request, vector_number};
            IDX_IRQ_STATUS: rbyte = {1'b0, irq_status_q};
            IDX_IRQ_MASK: rbyte = {1'b0, irq_mask_q};
            default: rd_known = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rbyte};
                s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // checks
    property p_level_clear;
        @(posedge aclk) disable iff (!aresetn)
        level_mode[0] |=> !ext_irq_flags_q[0];
    endproperty
    a_level_clear: assert property (p_level_clear)
        else $error("flag set in low-level mode");
    property p_rise_sets;
        @(posedge aclk) disable iff (!aresetn)
        (sense_control_q[1:0] == SENSE_RISE && ext_eff[0] && !ext_prev_q[0])
        |=> ext_irq_flags_q[0];
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("rising edge missed");
    property p_grp_set;
        @(posedge aclk) disable iff (!aresetn)
        (group_enable_q[2] && |(pin_changed[23:16] & pin_change_mask_q[2]))
        |=> pin_change_flags_q[2];
    endproperty
    a_grp_set: assert property (p_grp_set)
        else $error("group flag not set");
    property p_grp_gate;
        @(posedge aclk) disable iff (!aresetn)
        (!group_enable_q[1] && !pin_change_flags_q[1]) |=>
        !pin_change_flags_q[1];
    endproperty
    a_grp_gate: assert property (p_grp_gate)
        else $error("disabled group flagged");
    property p_mask_gate;
        @(posedge aclk) disable iff (!aresetn)
        (pin_change_mask_q[0] == 8'h00 && !pin_change_flags_q[0]) |=>
        !pin_change_flags_q[0];
    endproperty
    a_mask_gate: assert property (p_mask_gate)
        else $error("masked input flagged");
    property p_w1c;
        @(posedge aclk) disable iff (!aresetn)
        (pc_w1c[3] && !grp_event[3]) |=> !pin_change_flags_q[3];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write one did not clear");
    property p_no_gie;
        @(posedge aclk) disable iff (!aresetn)
        (!global_enable_q && !vector_request) |=> !vector_request;
    endproperty
    a_no_gie: assert property (p_no_gie)
        else $error("vector without global enable");
    property p_taken_clr;
        @(posedge aclk) disable iff (!aresetn)
        (vector_taken && vector_request && vector_number == VEC_GRP_BASE
        && !grp_event[0]) |=> !pin_change_flags_q[0];
    endproperty
    a_taken_clr: assert property (p_taken_clr)
        else $error("service did not clear flag");
    property p_reserved;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("upper read bits not zero");
    c_vector: cover property (@(posedge aclk) vector_request && vector_taken);
    c_grp: cover property (@(posedge aclk) grp_event[3]);
    c_ext: cover property (@(posedge aclk) ext_event[2]);
    c_irq: cover property (@(posedge aclk) irq);
endmodule
`default_nettype wire

// [verilog/pin_change_irq_pkg.sv]
/*
 * Package for the pin-change and external interrupt flag block.
 * Register indices, field positions, reset values, sense codes.
 * Assumes a 32-bit AXI4-Lite register bus.
 */
`default_nettype none
package pin_change_irq_pkg;
    // ==========================================================
    // register map: printed offsets are indices, byte = index*4
    localparam logic [7:0] IDX_PC_FLAGS = 8'h1B;
    localparam logic [7:0] IDX_EXT_FLAGS = 8'h1C;
    localparam logic [7:0] IDX_EXT_ENABLE = 8'h1D;
    localparam logic [7:0] IDX_PC_GROUP_ENABLE = 8'h68;
    localparam logic [7:0] IDX_SENSE_CONTROL = 8'h69;
    localparam logic [7:0] IDX_PC_MASK0 = 8'h6B;
    localparam logic [7:0] IDX_PC_MASK1 = 8'h6C;
    localparam logic [7:0] IDX_PC_MASK2 = 8'h6D;
    localparam logic [7:0] IDX_PC_MASK3 = 8'h73;
    localparam logic [7:0] IDX_STATUS = 8'h80;
    localparam logic [7:0] IDX_VECTOR = 8'h81;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h82;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h83;
    localparam int ADDR_W = 10;
    // ==========================================================
    // field layout and reset values
    localparam int N_EXT = 3;
    localparam int N_GRP = 4;
    localparam int GRP_W = 8;
    localparam int N_PINS = 32;
    localparam int N_EV = 7;
    localparam int GLOBAL_EN_BIT = 7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // vector numbers: 0 none, 1..3 external, 4..7 groups
    localparam logic [3:0] VEC_NONE = 4'h0;
    localparam logic [3:0] VEC_EXT_BASE = 4'h1;
    localparam logic [3:0] VEC_GRP_BASE = 4'h4;
    // sense control encoding
    typedef enum logic [1:0] {
        SENSE_LOW = 2'b00,
        SENSE_ANY = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } sense_type;
endpackage
`default_nettype wire
